// *** common/sbg_regs.vh ***
`ifndef SBG_REGS_VH
`define SBG_REGS_VH
// frame lengths in bit periods: start + data + stop
`define SBG_BITS_SHORT 4'd10
`define SBG_BITS_LONG 4'd11
// default bit period in clock cycles
`define SBG_BIT_CYCLES 16'd868
`define SBG_CNT_W 16
`endif

// *** src/sbg_bit_timer.v ***
`timescale 1ns/1ps
`default_nettype none
module sbg_bit_timer #(
  parameter CNT_W = 16
) (
  input  wire             clock_i,
  input  wire             resetn_i,
  input  wire             restart_i,
  input  wire [CNT_W-1:0] period_i,
  output reg              tick_o
);
  reg [CNT_W-1:0] count;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count  <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
    end else if (restart_i) begin
      // the restart edge is already the first cycle of the new bit period
      count  <= {{(CNT_W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end else if (count >= period_i - {{(CNT_W-1){1'b0}}, 1'b1}) begin
      count  <= {CNT_W{1'b0}};
      tick_o <= 1'b1;
    end else begin
      count  <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** src/sbg_break_gen.v ***
// Overview of operation
// (R01) setting then clearing the break request sends exactly one break character
// (R02) a break holds the line low 10 bit periods, 11 with long words
// (R03) breaks repeat back to back while requested; none added after clearing
// (R04) transmitter enable going off then on sends one idle frame first
// (R05) a break following an idle frame still has the correct length
// (R06) software issues idle then break with interrupts masked, nothing between
// (R07) word-length zero means 8 data bits, one means 9; plus start and stop
`timescale 1ns/1ps
`default_nettype none
`include "sbg_regs.vh"
module sbg_break_gen #(
  parameter BIT_CYCLES = `SBG_BIT_CYCLES
) (
  input  wire clock_i,
  input  wire resetn_i,
  input  wire break_request_bit_i,
  input  wire transmitter_on_bit_i,
  input  wire word_long_i,
  output reg  serial_out_o,
  output reg  break_active_o,
  output reg  idle_active_o
);
  localparam ST_OFF   = 3'b001;
  localparam ST_IDLE  = 3'b010;
  localparam ST_BREAK = 3'b100;

  // control bits come from the cpu side but are synchronised anyway
  reg [1:0] sync_brk;
  reg [1:0] sync_te;
  reg [1:0] sync_m;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_brk <= 2'b00;
      sync_te  <= 2'b00;
      sync_m   <= 2'b00;
    end else begin
      sync_brk <= {sync_brk[0], break_request_bit_i};
      sync_te  <= {sync_te[0], transmitter_on_bit_i};
      sync_m   <= {sync_m[0], word_long_i};
    end
  end
  wire brk_req = sync_brk[1];
  wire te_on   = sync_te[1];
  wire m_long  = sync_m[1];

  // (R07) start plus data plus stop, chosen per word length
  function [3:0] frame_bits;
    input long_word;
    begin
      if (long_word)
        frame_bits = `SBG_BITS_LONG;
      else
        frame_bits = `SBG_BITS_SHORT;
    end
  endfunction

  function in_break;
    input [2:0] st;
    begin
      in_break = (st == ST_BREAK);
    end
  endfunction

  function in_idle;
    input [2:0] st;
    begin
      in_idle = (st == ST_IDLE);
    end
  endfunction

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [3:0] bit_cnt;
  reg  [3:0] frame_len;
  reg        brk_pend;
  reg        idle_pend;
  reg        te_prev;
  wire       bit_tick;
  wire       start_frame;
  wire       frame_done;
  wire       te_rise;
  wire       brk_want;
  wire       idle_want;
  wire       brk_start;
  wire       idle_start;

  // last bit period of the frame in progress
  assign frame_done = bit_tick && (bit_cnt == frame_len - 4'd1);
  assign te_rise    = te_on && !te_prev;
  // a pulse shorter than an idle frame in progress survives in brk_pend; one during a break is not kept
  assign brk_want   = brk_req | brk_pend;
  assign idle_want  = te_rise | idle_pend;

  sbg_bit_timer #(
    .CNT_W(`SBG_CNT_W)
  ) u_timer (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .restart_i(start_frame),
    .period_i (BIT_CYCLES[`SBG_CNT_W-1:0]),
    .tick_o   (bit_tick)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        // (R04) enable rising sends one idle frame ahead of any break
        if (idle_want) begin
          next_state = ST_IDLE;
        end else if (te_on && brk_want) begin
          next_state = ST_BREAK;
        end
      end
      ST_IDLE: begin
        // (R05) break starts on a fresh frame, so its length is whole
        if (frame_done) begin
          if (idle_want) begin
            next_state = ST_IDLE;
          end else if (te_on && brk_want) begin
            next_state = ST_BREAK;
          end else begin
            next_state = ST_OFF;
          end
        end
      end
      ST_BREAK: begin
        // (R03) repeat only while still requested; an idle request goes first
        if (frame_done) begin
          if (idle_want) begin
            next_state = ST_IDLE;
          end else if (te_on && brk_req) begin
            next_state = ST_BREAK;
          end else begin
            next_state = ST_OFF;
          end
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // any change of state or end of frame restarts the bit timer
  assign start_frame = (state != next_state) || frame_done;
  assign brk_start   = start_frame && in_break(next_state);
  assign idle_start  = start_frame && in_idle(next_state);

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      te_prev <= 1'b0;
    end else begin
      te_prev <= te_on;
    end
  end

  // (R01) a request seen outside a break is kept until its break starts; that break serves it,
  // so it is dropped there and no second break follows a short pulse
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      brk_pend <= 1'b0;
    end else if (brk_start) begin
      brk_pend <= 1'b0;
    end else if (brk_req && !in_break(state)) begin
      brk_pend <= 1'b1;
    end
  end

  // (R04) an enable toggle seen mid-frame waits for the frame to end
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_pend <= 1'b0;
    end else if (idle_start) begin
      idle_pend <= 1'b0;
    end else if (te_rise) begin
      idle_pend <= 1'b1;
    end
  end

  // bit position within the frame on the line
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= 4'd0;
    end else if (start_frame) begin
      bit_cnt <= 4'd0;
    end else if (bit_tick) begin
      bit_cnt <= bit_cnt + 4'd1;
    end
  end

  // (R02) length latched once per frame, so a frame is never doubled
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_len <= `SBG_BITS_SHORT;
    end else if (start_frame) begin
      frame_len <= frame_bits(m_long);
    end
  end

  // line idles high and is driven low only for a break
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_out_o <= 1'b1;
    end else begin
      serial_out_o <= !in_break(next_state);
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      break_active_o <= 1'b0;
    end else begin
      break_active_o <= in_break(next_state);
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_active_o <= 1'b0;
    end else begin
      idle_active_o <= in_idle(next_state);
    end
  end
endmodule
`default_nettype wire

// *** test/sbg_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far-side receiver: measures each low run
module sbg_rx_model (
  input  wire logic clock_i,
  input  wire logic line_i,
  output var int    low_len,
  output var int    n_low
);
  int run = 0;
  initial begin
    low_len = 0;
    n_low = 0;
  end
  always @(posedge clock_i)
    if (!line_i) run <= run + 1;
    else if (run != 0) begin
      low_len <= run;
      n_low <= n_low + 1;
      run <= 0;
    end
endmodule
`default_nettype wire

// *** test/sbg_break_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbg_break_sva #(
  parameter BIT_CYCLES = 868
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic break_request_bit_i,
  input wire logic transmitter_on_bit_i,
  input wire logic word_long_i,
  input wire logic serial_out_o,
  input wire logic break_active_o,
  input wire logic idle_active_o
);
  int lo, hi, fl;
  assign fl = word_long_i ? 11 * BIT_CYCLES : 10 * BIT_CYCLES;
  always @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) begin
      lo <= 0;
      hi <= 0;
    end else begin
      lo <= break_active_o ? lo + 1 : 0;
      hi <= idle_active_o ? hi + 1 : 0;
    end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_idle; idle_active_o && serial_out_o; endsequence
  a_brk_low: assert property (break_active_o |-> !serial_out_o) else $error("break high");
  a_idle_first: assert property ($rose(transmitter_on_bit_i) |-> ##[2:4] s_idle ##1 s_idle)
    else $error("no idle");
  a_brk_len: assert property ($fell(break_active_o) |-> lo % fl == 0) else $error("brk len");
  a_idle_len: assert property ($fell(idle_active_o) |-> hi == fl) else $error("idle len");
  a_no_overlap: assert property (!(break_active_o && idle_active_o)) else $error("overlap");
  a_off_quiet: assert property ((!transmitter_on_bit_i)[*4] |-> !idle_active_o)
    else $error("idle while off");
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int BC = 4;
  logic clock_i = 0, resetn_i = 0, brk = 0, te = 0, wl = 0, so, ba, ia;
  int n_fail = 0, compares = 0, low_len, n_low, n0;
  sbg_break_gen #(.BIT_CYCLES(BC)) u_dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .break_request_bit_i(brk), .transmitter_on_bit_i(te), .word_long_i(wl),
    .serial_out_o(so), .break_active_o(ba), .idle_active_o(ia));
  sbg_rx_model u_rx (.clock_i(clock_i), .line_i(so), .low_len(low_len), .n_low(n_low));
  initial forever #5 clock_i = ~clock_i;
  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      n_fail++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic stop_test;
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // software idles then breaks with nothing between
  task automatic idle_break(input logic m);
    n0 = n_low;
    @(posedge clock_i) begin wl <= m; te <= 0; end
    repeat (2) @(posedge clock_i);
    te <= 1;
    @(posedge clock_i) brk <= 1;
    repeat (3) @(posedge clock_i);
    brk <= 0;
    repeat (130) @(posedge clock_i);
    check(low_len == (10 + m) * BC && n_low == n0 + 1, "single break");
  endtask
  // held 60 cycles: two 40-cycle breaks, no third
  task automatic held_break;
    n0 = n_low;
    @(posedge clock_i) begin wl <= 0; brk <= 1; end
    repeat (60) @(posedge clock_i);
    brk <= 0;
    repeat (80) @(posedge clock_i);
    check(low_len == 2 * 10 * BC && n_low == n0 + 1, "held break");
  endtask
  // short pulse on a quiet line: one break, none after it
  task automatic pulse_break;
    n0 = n_low;
    @(posedge clock_i) begin wl <= 0; brk <= 1; end
    repeat (3) @(posedge clock_i);
    brk <= 0;
    repeat (130) @(posedge clock_i);
    check(low_len == 10 * BC && n_low == n0 + 1, "pulse break");
  endtask
  // enable held off keeps the line quiet; enable on sends an idle frame
  task automatic off_quiet;
    @(posedge clock_i) te <= 0;
    repeat (20) @(posedge clock_i);
    check(so === 1'b1 && ba === 1'b0 && ia === 1'b0, "quiet while off");
    te <= 1;
    repeat (4) @(posedge clock_i);
    check(ia === 1'b1 && so === 1'b1 && ba === 1'b0, "idle on enable");
    repeat (50) @(posedge clock_i);
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    check(so === 1'b1 && ba === 1'b0, "reset line");
    resetn_i <= 1;
    idle_break(0);
    idle_break(1);
    held_break();
    pulse_break();
    off_quiet();
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge clock_i);
    n_fail++;
    stop_test();
  end
endmodule
bind sbg_break_gen sbg_break_sva #(.BIT_CYCLES(BIT_CYCLES)) u_sva (.clock_i(clock_i),
  .resetn_i(resetn_i), .break_request_bit_i(break_request_bit_i),
  .transmitter_on_bit_i(transmitter_on_bit_i), .word_long_i(word_long_i),
  .serial_out_o(serial_out_o), .break_active_o(break_active_o), .idle_active_o(idle_active_o));
`default_nettype wire
